// ==== verilog/dmac_map.vh ====
`ifndef DMAC_MAP_VH
`define DMAC_MAP_VH
`define DMAC_OP_LOAD 2'h0
`define DMAC_OP_ADD 2'h1
`define DMAC_OP_SUB 2'h2
`define DMAC_FMT_DEF 3'h0
`define DMAC_FMT_UFRAC 3'h1
`define DMAC_FMT_SINT 3'h2
`define DMAC_FMT_SFRAC2 3'h3
`define DMAC_FMT_SINT2 3'h4
`define DMAC_ACC_MAX 40'h7FFFFFFFFF
`define DMAC_ACC_MIN 40'h8000000000
`define DMAC_D_MAX 32'h7FFFFFFF
`define DMAC_D_MIN 32'h80000000
`define DMAC_FRAC_MAXP 32'h7FFF0000
`define DMAC_ACC_RST 40'h0000000000
`define DMAC_D_RST 32'h00000000
`endif

// ==== verilog/dmac_unit.v ====
`include "dmac_map.vh"
`default_nettype none
// dual multiply-accumulate to data register datapath, one cycle per operation
module dmac_unit (
   input wire clk,
   input wire arst_n,
   input wire op_valid,
   input wire unit_sel,
   input wire [1:0] acc_op,
   input wire [2:0] fmt_opt,
   input wire mixed_opt,
   input wire [2:0] dest_pair,
   input wire [31:0] src0_reg,
   input wire [31:0] src1_reg,
   input wire src0_high,
   input wire src1_high,
   input wire rnd_mode_bit,
   output wire [39:0] accumulator_zero,
   output wire [39:0] accumulator_one,
   output wire dreg_wr,
   output wire [2:0] dreg_idx,
   output wire [31:0] dreg_data,
   output wire data_sat_flag,
   output wire data_saturation_sticky,
   output wire acc_even_sat_flag,
   output wire acc_even_sat_sticky,
   output wire acc_odd_sat_flag,
   output wire acc_odd_sat_sticky,
   output wire op_done
);
   // saturate a 42-bit signed value to the 40-bit accumulator range
   function [40:0] sat40;
      input [41:0] v;
      begin
         if (!v[41] && (v[40:39] != 2'h0))
            sat40 = {1'b1, `DMAC_ACC_MAX};
         else if (v[41] && (v[40:39] != 2'h3))
            sat40 = {1'b1, `DMAC_ACC_MIN};
         else
            sat40 = {1'b0, v[39:0]};
      end
   endfunction

   // saturate a 41-bit signed value to 32 bits
   function [32:0] sat32;
      input [40:0] v;
      begin
         if (!v[40] && (v[39:31] != 9'h000))
            sat32 = {1'b1, `DMAC_D_MAX};
         else if (v[40] && (v[39:31] != 9'h1FF))
            sat32 = {1'b1, `DMAC_D_MIN};
         else
            sat32 = {1'b0, v[31:0]};
      end
   endfunction

   // pick one half-word of a source register
   function [15:0] pick_half;
      input [31:0] r;
      input hi;
      begin
         if (hi)
            pick_half = r[31:16];
         else
            pick_half = r[15:0];
      end
   endfunction

   // widen a half-word to 18 bits, sign-filled only when it counts as signed
   function [17:0] widen18;
      input [15:0] h;
      input sgn;
      begin
         widen18 = {sgn & h[15], sgn & h[15], h};
      end
   endfunction

   // true for the one operand pair whose fractional product overflows
   function min_pair;
      input [15:0] a;
      input [15:0] b;
      begin
         min_pair = (a == 16'h8000) & (b == 16'h8000);
      end
   endfunction

   // sign-extend a stored accumulator to the 42-bit working width
   function [41:0] acc_ext;
      input [39:0] a;
      begin
         acc_ext = {a[39], a[39], a};
      end
   endfunction

   // accumulators; the ports are plain copies of these
   reg [39:0] acc_zero_r;
   reg [39:0] acc_zero_nxt;
   reg [39:0] acc_one_r;
   reg [39:0] acc_one_nxt;

   // write-back to the register file
   reg dwr_r;
   reg dwr_nxt;
   reg [2:0] didx_r;
   reg [2:0] didx_nxt;
   reg [31:0] ddata_r;
   reg [31:0] ddata_nxt;
   reg done_r;
   reg done_nxt;

   // saturation flags and their sticky copies
   reg dsat_r;
   reg dsat_nxt;
   reg dstk_r;
   reg dstk_nxt;
   reg esat_r;
   reg esat_nxt;
   reg estk_r;
   reg estk_nxt;
   reg osat_r;
   reg osat_nxt;
   reg ostk_r;
   reg ostk_nxt;

   // operand and decode terms
   reg [15:0] opa;
   reg [15:0] opb;
   reg a_sgn;
   reg b_sgn;
   reg frac_shift;
   reg scale2;
   reg mixed;
   reg both_min;

   // arithmetic terms; 42 bits hold any 40-bit sum or difference without wrap
   reg [35:0] raw_prod;
   reg [33:0] prod;
   reg [41:0] pext;
   reg [39:0] acc_cur;
   reg [41:0] aext;
   reg [41:0] sum;
   reg [40:0] acc_sat;
   reg [40:0] scaled;
   reg [32:0] d_sat;

   // operand pick: each operand is one half of its source register
   always @* begin
      opa = pick_half(src0_reg, src0_high);
      opb = pick_half(src1_reg, src1_high);
   end

   // format decode; the mixed option only ever reaches the odd unit
   always @* begin
      mixed = mixed_opt & unit_sel;
      // mixed may pair with one other format, which still sets the copy scaling
      a_sgn = (fmt_opt != `DMAC_FMT_UFRAC) | mixed;
      b_sgn = (fmt_opt != `DMAC_FMT_UFRAC) & ~mixed;
      frac_shift = ((fmt_opt == `DMAC_FMT_DEF) | (fmt_opt == `DMAC_FMT_SFRAC2))
         & ~mixed;
      scale2 = (fmt_opt == `DMAC_FMT_SFRAC2) | (fmt_opt == `DMAC_FMT_SINT2);
   end

   // one signed 18-bit multiplier serves the signed, unsigned and mixed forms
   always @* begin
      raw_prod = $signed(widen18(opa, a_sgn)) * $signed(widen18(opb, b_sgn));
      both_min = min_pair(opa, opb);
      // clamp the single overflowing fraction before it can reach an accumulator
      if (frac_shift & both_min)
         prod = {2'h0, `DMAC_FRAC_MAXP};
      else if (frac_shift)
         prod = {raw_prod[32:0], 1'b0};
      else
         prod = raw_prod[33:0];
      // widen the product to the working width, keeping its sign
      pext = {{8{prod[33]}}, prod};
   end

   // accumulator update against the unit's own accumulator, clamped to 40 bits
   always @* begin
      acc_cur = unit_sel ? acc_one_r : acc_zero_r;
      aext = acc_ext(acc_cur);
      // code 3 is not defined and behaves as a load
      case (acc_op)
         `DMAC_OP_ADD: sum = aext + pext;
         `DMAC_OP_SUB: sum = aext - pext;
         default: sum = pext;
      endcase
      // a sum outside 40 bits raises the accumulator's saturation flag
      acc_sat = sat40(sum);
   end

   // copy out: doubling touches only the copy, so the stored accumulator stays unscaled
   always @* begin
      // a doubled 40-bit value still fits the 41-bit copy width
      if (scale2)
         scaled = {acc_sat[39:0], 1'b0};
      else
         scaled = {acc_sat[39], acc_sat[39:0]};
      // no rounding term is added and the rounding-mode input is never read
      d_sat = sat32(scaled);
   end

   // next values; whatever an operation does not touch keeps its value
   always @* begin
      acc_zero_nxt = acc_zero_r;
      acc_one_nxt = acc_one_r;
      didx_nxt = didx_r;
      ddata_nxt = ddata_r;
      // flags hold between operations
      dsat_nxt = dsat_r;
      dstk_nxt = dstk_r;
      esat_nxt = esat_r;
      estk_nxt = estk_r;
      osat_nxt = osat_r;
      ostk_nxt = ostk_r;
      // the write strobe and the completion pulse follow op_valid one cycle later, so back-to-back operations hold them high
      dwr_nxt = op_valid;
      done_nxt = op_valid;
      if (op_valid) begin
         // the unit picks the even or odd data register of the destination pair
         didx_nxt = {dest_pair[1:0], unit_sel};
         ddata_nxt = d_sat[31:0];
         dsat_nxt = d_sat[32];
         dstk_nxt = dstk_r | d_sat[32];
         // each unit touches only its own accumulator and accumulator flags; both units write the data flags
         if (unit_sel) begin
            acc_one_nxt = acc_sat[39:0];
            osat_nxt = acc_sat[40];
            ostk_nxt = ostk_r | acc_sat[40];
         end else begin
            acc_zero_nxt = acc_sat[39:0];
            esat_nxt = acc_sat[40];
            estk_nxt = estk_r | acc_sat[40];
         end
      end
   end

   // accumulators commit on the same edge as the write-back and the flags
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_zero_r <= `DMAC_ACC_RST;
         acc_one_r <= `DMAC_ACC_RST;
      end else begin
         acc_zero_r <= acc_zero_nxt;
         acc_one_r <= acc_one_nxt;
      end
   end

   // write-back registers; the strobe is a one-cycle pulse per operation
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dwr_r <= 1'b0;
         didx_r <= 3'h0;
         ddata_r <= `DMAC_D_RST;
         done_r <= 1'b0;
      end else begin
         dwr_r <= dwr_nxt;
         didx_r <= didx_nxt;
         ddata_r <= ddata_nxt;
         done_r <= done_nxt;
      end
   end

   // status flags; a sticky bit is only ever cleared by reset
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dsat_r <= 1'b0;
         dstk_r <= 1'b0;
         esat_r <= 1'b0;
         estk_r <= 1'b0;
         osat_r <= 1'b0;
         ostk_r <= 1'b0;
      end else begin
         dsat_r <= dsat_nxt;
         dstk_r <= dstk_nxt;
         esat_r <= esat_nxt;
         estk_r <= estk_nxt;
         osat_r <= osat_nxt;
         ostk_r <= ostk_nxt;
      end
   end

   // ports mirror the registers so every data output comes straight from a flip-flop
   assign accumulator_zero = acc_zero_r;
   assign accumulator_one = acc_one_r;
   assign dreg_wr = dwr_r;
   assign dreg_idx = didx_r;
   assign dreg_data = ddata_r;
   assign op_done = done_r;

   // only these six status bits are driven here; all others live elsewhere
   assign data_sat_flag = dsat_r;
   assign data_saturation_sticky = dstk_r;
   assign acc_even_sat_flag = esat_r;
   assign acc_even_sat_sticky = estk_r;
   assign acc_odd_sat_flag = osat_r;
   assign acc_odd_sat_sticky = ostk_r;

   // the rounding-mode bit and the spare pair bit are accepted but have no effect
   wire unused_ok;
   assign unused_ok = rnd_mode_bit | dest_pair[2];
endmodule // dmac_unit
`default_nettype wire

// ==== test/dmac_sva.sv ====
`default_nettype none
// sees only the datapath ports
module dmac_sva (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic op_valid,
   input wire logic unit_sel,
   input wire logic dreg_wr,
   input wire logic op_done,
   input wire logic [2:0] dest_pair,
   input wire logic [2:0] dreg_idx,
   input wire logic [31:0] dreg_data,
   input wire logic [39:0] accumulator_zero,
   input wire logic [39:0] accumulator_one,
   input wire logic data_sat_flag,
   input wire logic data_saturation_sticky,
   input wire logic acc_even_sat_flag,
   input wire logic acc_even_sat_sticky,
   input wire logic acc_odd_sat_flag,
   input wire logic acc_odd_sat_sticky
);
   timeunit 1ns;
   timeprecision 100ps;
   wire [5:0] fl = {data_sat_flag, data_saturation_sticky, acc_even_sat_flag,
      acc_even_sat_sticky, acc_odd_sat_flag, acc_odd_sat_sticky};
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // write-back and flags land one cycle after issue, all together
   done_next_a: assert property (op_valid |=> dreg_wr && op_done) else $error("late");
   idle_quiet_a: assert property (!op_valid |=> !dreg_wr && !op_done && $stable(fl))
      else $error("idle change");
   even_side_a: assert property (op_valid && !unit_sel |=> !dreg_idx[0] &&
      $stable(accumulator_one) && $stable(fl[1:0])) else $error("even leak");
   odd_side_a: assert property (op_valid && unit_sel |=> dreg_idx[0] &&
      $stable(accumulator_zero) && $stable(fl[3:2])) else $error("odd leak");
   pair_sel_a: assert property (op_valid |=> dreg_idx[2:1] == $past(dest_pair[1:0]))
      else $error("pair");
   // a sticky copy never lags its flag and never drops
   data_stk_a: assert property (data_sat_flag |-> data_saturation_sticky)
      else $error("data sticky");
   acc_stk_a: assert property (fl[3:2] != 2'h2 && fl[1:0] != 2'h2)
      else $error("acc sticky");
   stk_hold_a: assert property (($past(fl) & ~fl & 6'h15) == 6'h0)
      else $error("sticky drop");
   // a saturated copy is always one of the two range limits
   sat_value_a: assert property (data_sat_flag |-> dreg_data == 32'h7FFFFFFF ||
      dreg_data == 32'h80000000) else $error("sat value");
   cover property (acc_even_sat_flag);
   cover property (acc_odd_sat_flag);
   cover property (op_valid ##1 op_valid);
endmodule // dmac_sva
`default_nettype wire

// ==== test/dmac_rf.sv ====
`default_nettype none
// register file side: keeps whatever the datapath writes back
module dmac_rf (
   input wire logic clk,
   input wire logic wr,
   input wire logic [2:0] idx,
   input wire logic [31:0] data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] r_r [8];
   // capture on the edge that sees the pulse, so a later read gets it
   always @(posedge clk) if (wr) r_r[idx] <= data;
endmodule // dmac_rf
`default_nettype wire

// ==== test/dmac_unit_tb.sv ====
`default_nettype none
module dmac_unit_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, arst_n = 1'b0, op_valid = 1'b0, unit_sel = 1'b0, mixed_opt = 1'b0;
   logic src0_high = 1'b0, src1_high = 1'b0, rnd_mode_bit = 1'b0;
   logic [1:0] acc_op = 2'h0;
   logic [2:0] fmt_opt = 3'h0, dest_pair = 3'h0, li;
   logic [31:0] src0_reg = 32'h0, src1_reg = 32'h0, ld;
   wire [39:0] accumulator_zero, accumulator_one;
   wire [31:0] dreg_data;
   wire [2:0] dreg_idx;
   wire dreg_wr, data_sat_flag, data_saturation_sticky, acc_even_sat_flag, acc_even_sat_sticky;
   wire acc_odd_sat_flag, acc_odd_sat_sticky, op_done;
   int fails = 0, compares = 0, n = 0;
   always #12.5 clk = ~clk;
   dmac_unit uut (.*);
   dmac_rf rf (.clk, .wr(dreg_wr), .idx(dreg_idx), .data(dreg_data));
   task automatic chk(input logic [79:0] g, e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // c = {unit, op, format, mixed}; the unused half carries the inverse as a decoy
   task automatic d(input logic [6:0] c, input logic [15:0] a, b);
      @(posedge clk);
      n++;
      {op_valid, unit_sel, acc_op, fmt_opt, mixed_opt, dest_pair, rnd_mode_bit} <= {1'b1, c, n[3:0]};
      {src0_high, src1_high} <= {n[1], ~n[1]};
      src0_reg <= n[1] ? {a, ~a} : {~a, a};
      src1_reg <= n[1] ? {~b, b} : {b, ~b};
   endtask
   task automatic t(input logic [6:0] c, input logic [15:0] a, b, input logic [39:0] ea,
      input logic [31:0] ed, input logic [3:0] fl);
      d(c, a, b);
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      li = {n[2:1], c[6]};
      ld = ed;
      chk({c[6] ? accumulator_one : accumulator_zero, dreg_data, dreg_idx, dreg_wr,
         data_sat_flag, data_saturation_sticky, c[6] ? {acc_odd_sat_flag, acc_odd_sat_sticky} :
         {acc_even_sat_flag, acc_even_sat_sticky}}, {ea, ed, li, 1'b1, fl});
      chk({79'h0, op_done}, {79'h0, 1'b1});
      $display("test %0d done", n);
   endtask
   // operations one after another; the flag column is {sat, sticky, acc sat, acc sticky}
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      t(7'h00,16'h4000,16'h4000,40'h20000000,32'h20000000,4'h0);
      t(7'h10,16'h8000,16'h8000,40'h9FFF0000,32'h7FFFFFFF,4'hC);
      t(7'h20,16'h8000,16'h8000,40'h20000000,32'h20000000,4'h4);
      t(7'h42,16'h8000,16'h8000,40'h40000000,32'h40000000,4'h4);
      t(7'h44,16'hFFFF,16'h0003,40'hFFFFFFFFFD,32'hFFFFFFFD,4'h4);
      t(7'h46,16'h4000,16'h4000,40'h20000000,32'h40000000,4'h4);
      t(7'h08,16'hFFFF,16'h0003,40'hFFFFFFFFFD,32'hFFFFFFFA,4'h4);
      t(7'h45,16'hFFFF,16'hFFFF,40'hFFFFFF0001,32'hFFFF0001,4'h4);
      t(7'h01,16'hFFFF,16'hFFFF,40'h0000000002,32'h00000002,4'h4);
      // 257 maximal products overrun the 40-bit range; back to back on purpose
      for (int u = 0; u < 2; u++) begin
         d({u[0], 6'h00}, 16'h8000, 16'h8000);
         repeat (255) d({u[0], 6'h10}, 16'h8000, 16'h8000);
         t({u[0],6'h10},16'h8000,16'h8000,40'h7FFFFFFFFF,32'h7FFFFFFF,4'hF);
         t({u[0],6'h00},16'h4000,16'h4000,40'h20000000,32'h20000000,4'h5);
      end
      // the register file captures one edge after the strobe appears
      @(posedge clk);
      #1;
      chk({48'h0, rf.r_r[li]}, {48'h0, ld});
      // mid-run reset clears accumulators, strobes and sticky flags alike
      @(posedge clk);
      arst_n <= 1'b0;
      #1;
      chk({accumulator_zero, accumulator_one}, 80'h0);
      chk({37'h0, dreg_data, dreg_idx, dreg_wr, op_done, data_sat_flag,
         data_saturation_sticky, acc_even_sat_flag, acc_even_sat_sticky, acc_odd_sat_flag,
         acc_odd_sat_sticky}, 80'h0);
      $display("test reset done");
      @(posedge clk);
      arst_n <= 1'b1;
      t(7'h40,16'h4000,16'h4000,40'h20000000,32'h20000000,4'h0);
      report_and_stop();
   end
   // about 550 cycles of work; this leaves ample slack
   initial begin
      #100000;
      fails++;
      report_and_stop();
   end
   task automatic report_and_stop();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
endmodule // dmac_unit_tb
bind dmac_unit dmac_sva sva (.*);
`default_nettype wire
